/* iopc_top.sv */
`timescale 1ns/1ps
module iopc_top (
  // bus
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // port A pads
  input  wire logic [7:0]  pa_in,
  output logic      [7:0]  pa_out,
  output logic      [7:0]  pa_oe_n,
  output logic      [7:0]  pa_pullhigh,
  output logic      [7:0]  pa_pulllow,
  // port B pads
  input  wire logic [5:0]  pb_in,
  output logic      [5:0]  pb_out,
  output logic      [5:0]  pb_oe_n,
  output logic      [5:0]  pb_pullhigh,
  output logic      [5:0]  pb_pulllow,
  // peripheral signals
  input  wire logic        ir_carrier,
  input  wire logic        instr_clk,
  input  wire logic        cmp_out,
  input  wire logic        pwm_one,
  input  wire logic        buzzer_one,
  input  wire logic        pwm_two,
  input  wire logic        buzzer_two,
  // to core
  output logic             level_change_irq,
  output logic             ext_irq0,
  output logic             ext_irq1,
  output logic             ext_timer_clk_a,
  output logic             ext_timer_clk_b,
  output logic             pin_reset_n,
  output logic             xtal_mode,
  output logic      [1:0]  sink_mode,
  output logic             drive_large
);
  import iopc_pkg::*;

  // ----------------------------------------------------------
  // register state
  // ----------------------------------------------------------
  logic [7:0] port_a_data, port_a_direction, port_a_pullhigh_ctl;
  logic [5:0] port_b_data, port_b_direction, port_b_pullhigh_ctl;
  logic [7:0] shared_pulllow_ctl, power_ctl_reg, port_a_wake_select;
  logic [5:0] port_b_opendrain_ctl, port_b_wake_select;
  logic [7:0] interrupt_flag_reg, interrupt_enable_reg, power_ctl1_reg;
  logic [7:0] edge_select_reg, ir_ctl_reg, cfg_word;
  logic [9:0] periph_sel;

  // ----------------------------------------------------------
  // bus slave: zero wait from the first edge after reset, always OKAY
  // ----------------------------------------------------------
  logic       wr_pend;
  logic [7:0] wr_addr;
  wire        take = hsel & hready & htrans[1];

  // address phase capture for writes
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      wr_addr <= RST_ZERO;
    end else begin
      wr_pend <= take & hwrite;
      wr_addr <= haddr[7:0];
    end
  end

  // fixed answer signals
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b0;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  // ----------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------
  logic [13:0] pin_meta, pin_sync, pin_prev;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_meta <= 14'h0000;
      pin_sync <= 14'h0000;
      pin_prev <= 14'h0000;
    end else begin
      pin_meta <= {pb_in, pa_in};
      pin_sync <= pin_meta;
      pin_prev <= pin_sync;
    end
  end

  // read data mux; unmapped addresses read zero
  logic [31:0] rd_word;
  always_comb begin
    rd_word = 32'h0000_0000;
    unique case (haddr[7:0])
      ADDR_PA_DATA: rd_word[7:0] = pin_sync[7:0];
      ADDR_PB_DATA: rd_word[5:0] = pin_sync[13:8];
      ADDR_PA_DIR:  rd_word[7:0] = port_a_direction;
      ADDR_PB_DIR:  rd_word[5:0] = port_b_direction;
      ADDR_PA_PH:   rd_word[7:0] = port_a_pullhigh_ctl;
      ADDR_PB_PH:   rd_word[5:0] = port_b_pullhigh_ctl;
      ADDR_PL:      rd_word[7:0] = shared_pulllow_ctl;
      ADDR_PWR:     rd_word[7:0] = power_ctl_reg;
      ADDR_PB_OD:   rd_word[5:0] = port_b_opendrain_ctl;
      ADDR_PA_WAKE: rd_word[7:0] = port_a_wake_select;
      ADDR_PB_WAKE: rd_word[5:0] = port_b_wake_select;
      ADDR_IFLAG:   rd_word[7:0] = interrupt_flag_reg;
      ADDR_IEN:     rd_word[7:0] = interrupt_enable_reg;
      ADDR_PWR1:    rd_word[7:0] = power_ctl1_reg;
      ADDR_EDGE:    rd_word[7:0] = edge_select_reg;
      ADDR_IR:      rd_word[7:0] = ir_ctl_reg;
      ADDR_PERIPH:  rd_word[9:0] = periph_sel;
      ADDR_CFG:     rd_word[7:0] = cfg_word;
      default:      rd_word = 32'h0000_0000;
    endcase
  end

  // read data registered at address phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) hrdata <= 32'h0000_0000;
    else if (take && !hwrite) hrdata <= rd_word;
  end

  // ----------------------------------------------------------
  // control registers
  // ----------------------------------------------------------
  function automatic logic hit(input logic [7:0] a);
    hit = wr_pend && (wr_addr == a);
  endfunction

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      port_a_data          <= RST_ZERO;
      port_b_data          <= RST_ZERO[5:0];
      port_a_direction     <= RST_DIR;
      port_b_direction     <= RST_DIR[5:0];
      port_a_pullhigh_ctl  <= RST_ZERO;
      port_b_pullhigh_ctl  <= RST_ZERO[5:0];
      shared_pulllow_ctl   <= RST_ZERO;
      power_ctl_reg        <= RST_ZERO;
      port_b_opendrain_ctl <= RST_ZERO[5:0];
      port_a_wake_select   <= RST_ZERO;
      port_b_wake_select   <= RST_ZERO[5:0];
      interrupt_enable_reg <= RST_ZERO;
      power_ctl1_reg       <= RST_ZERO;
      edge_select_reg      <= RST_ZERO;
      ir_ctl_reg           <= RST_ZERO;
      periph_sel           <= RST_PERIPH;
      cfg_word             <= RST_CFG;
    end else begin
      if (hit(ADDR_PA_DATA)) port_a_data <= hwdata[7:0];
      if (hit(ADDR_PB_DATA)) port_b_data <= hwdata[5:0];
      if (hit(ADDR_PA_DIR))  port_a_direction <= hwdata[7:0];
      if (hit(ADDR_PB_DIR))  port_b_direction <= hwdata[5:0];
      if (hit(ADDR_PA_PH))   port_a_pullhigh_ctl <= hwdata[7:0];
      if (hit(ADDR_PB_PH))   port_b_pullhigh_ctl <= hwdata[5:0];
      if (hit(ADDR_PL))      shared_pulllow_ctl <= hwdata[7:0];
      if (hit(ADDR_PWR))     power_ctl_reg <= hwdata[7:0];
      if (hit(ADDR_PB_OD))   port_b_opendrain_ctl <= hwdata[5:0];
      if (hit(ADDR_PA_WAKE)) port_a_wake_select <= hwdata[7:0];
      if (hit(ADDR_PB_WAKE)) port_b_wake_select <= hwdata[5:0];
      if (hit(ADDR_IEN))     interrupt_enable_reg <= hwdata[7:0];
      if (hit(ADDR_PWR1))    power_ctl1_reg <= hwdata[7:0];
      if (hit(ADDR_EDGE))    edge_select_reg <= hwdata[7:0];
      if (hit(ADDR_IR))      ir_ctl_reg <= hwdata[7:0];
      if (hit(ADDR_PERIPH))  periph_sel <= hwdata[9:0];
      if (hit(ADDR_CFG))     cfg_word <= hwdata[7:0];
    end
  end

  // ----------------------------------------------------------
  // level change detection
  // ----------------------------------------------------------
  logic [13:0] wake_mask;
  logic        any_change;
  always_comb begin
    wake_mask = {port_b_wake_select, port_a_wake_select};
    if (edge_select_reg[BIT_EXT_IRQ0_SELECT]) wake_mask[8] = 1'b0;
    if (edge_select_reg[BIT_EXT_IRQ1_SELECT]) wake_mask[9] = 1'b0;
    any_change = |((pin_sync ^ pin_prev) & wake_mask);
  end

  // flag register: set wins over software clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) interrupt_flag_reg <= RST_ZERO;
    else begin
      if (hit(ADDR_IFLAG)) interrupt_flag_reg <= hwdata[7:0];
      if (any_change) interrupt_flag_reg[BIT_LVL_FLAG] <= 1'b1;
    end
  end

  // ----------------------------------------------------------
  // pin outputs
  // ----------------------------------------------------------
  logic [7:0] next_pa_out, next_pa_oe_n, next_pa_ph, next_pa_pl;
  logic [5:0] next_pb_out, next_pb_oe_n, next_pb_ph, next_pb_pl;
  logic       xtal_on, clkout_on;
  always_comb begin
    xtal_on   = cfg_word[BIT_XTAL];
    clkout_on = cfg_word[BIT_CLKOUT] & ~xtal_on;
    next_pa_out = port_a_data;
    next_pb_out = port_b_data;
    next_pa_oe_n = port_a_direction;
    next_pb_oe_n = port_b_direction;
    if (periph_sel[BIT_CMP_OE])       next_pb_out[3] = cmp_out;
    else if (periph_sel[BIT_PWM1_OE]) next_pb_out[3] = pwm_one;
    else if (periph_sel[BIT_BZ1_EN])  next_pb_out[3] = buzzer_one;
    if (periph_sel[BIT_PWM2_OE])      next_pb_out[2] = pwm_two;
    else if (periph_sel[BIT_BZ2_EN])  next_pb_out[2] = buzzer_two;
    if (ir_ctl_reg[BIT_IR_CARRIER_EN]) begin
      if (cfg_word[BIT_IR_LARGE]) begin
        next_pa_out[3]  = ir_carrier;
        next_pa_oe_n[3] = 1'b0;
      end else begin
        next_pb_out[1]  = ir_carrier;
        next_pb_oe_n[1] = 1'b0;
      end
    end
    for (int i = 0; i < 6; i++) begin
      if (port_b_opendrain_ctl[i] && next_pb_out[i])
        next_pb_oe_n[i] = 1'b1;
    end
    if (next_pa_out[5]) next_pa_oe_n[5] = 1'b1;
    if (cfg_word[BIT_RST_PIN]) next_pa_oe_n[5] = 1'b1;
    if (clkout_on) begin
      next_pa_out[7]  = instr_clk;
      next_pa_oe_n[7] = 1'b0;
    end
    if (xtal_on) begin
      next_pa_out[7:6]  = 2'b00;
      next_pa_oe_n[7:6] = 2'b11;
    end
    next_pa_ph    = port_a_pullhigh_ctl;
    next_pa_ph[5] = power_ctl_reg[BIT_PA5_PH];
    next_pb_ph    = port_b_pullhigh_ctl;
    next_pa_pl    = {2'b00, port_a_pullhigh_ctl[5], 1'b0,
                     shared_pulllow_ctl[3:0]};
    next_pb_pl    = {2'b00, shared_pulllow_ctl[7:4]};
    next_pa_ph = next_pa_ph & next_pa_oe_n;
    next_pa_pl = next_pa_pl & next_pa_oe_n;
    next_pb_ph = next_pb_ph & next_pb_oe_n;
    next_pb_pl = next_pb_pl & next_pb_oe_n;
    if (xtal_on) begin
      next_pa_ph[7:6] = 2'b00;
    end
  end

  // registered pad drive
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pa_out      <= RST_ZERO;
      pa_oe_n     <= RST_DIR;
      pa_pullhigh <= RST_ZERO;
      pa_pulllow  <= RST_ZERO;
      pb_out      <= RST_ZERO[5:0];
      pb_oe_n     <= RST_DIR[5:0];
      pb_pullhigh <= RST_ZERO[5:0];
      pb_pulllow  <= RST_ZERO[5:0];
    end else begin
      pa_out      <= next_pa_out;
      pa_oe_n     <= next_pa_oe_n;
      pa_pullhigh <= next_pa_ph;
      pa_pulllow  <= next_pa_pl;
      pb_out      <= next_pb_out;
      pb_oe_n     <= next_pb_oe_n;
      pb_pullhigh <= next_pb_ph;
      pb_pulllow  <= next_pb_pl;
    end
  end

  // ----------------------------------------------------------
  // core-facing outputs
  // ----------------------------------------------------------
  iopc_sink_t next_sink;
  always_comb begin
    if (!cfg_word[BIT_SMALLSNK])  next_sink = IOPC_SINK_SMALL;
    else if (!cfg_word[BIT_SINK]) next_sink = IOPC_SINK_NORMAL;
    else if (!cfg_word[BIT_CSC])  next_sink = IOPC_SINK_LARGE;
    else                          next_sink = IOPC_SINK_CONST;
  end

  // registered interrupt, clock and mode outputs
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      level_change_irq <= 1'b0;
      ext_irq0         <= 1'b0;
      ext_irq1         <= 1'b0;
      ext_timer_clk_a  <= 1'b0;
      ext_timer_clk_b  <= 1'b0;
      pin_reset_n      <= 1'b1;
      xtal_mode        <= 1'b0;
      sink_mode        <= IOPC_SINK_SMALL;
      drive_large      <= 1'b0;
    end else begin
      level_change_irq <= interrupt_flag_reg[BIT_LVL_FLAG]
                        & interrupt_enable_reg[BIT_LVL_FLAG]
                        & power_ctl1_reg[BIT_GIE];
      ext_irq0 <= edge_select_reg[BIT_EXT_IRQ0_SELECT] & pin_sync[8];
      ext_irq1 <= edge_select_reg[BIT_EXT_IRQ1_SELECT] & pin_sync[9];
      ext_timer_clk_a <= ((periph_sel[BIT_T0_SRC]
                          & ~periph_sel[BIT_T0_LCK])
                          | periph_sel[BIT_T1_SRC]) & pin_sync[4];
      ext_timer_clk_b <= (periph_sel[BIT_T2_SRC]
                          | periph_sel[BIT_T3_SRC]) & pin_sync[1];
      pin_reset_n <= ~(cfg_word[BIT_RST_PIN] & ~pin_sync[5]);
      xtal_mode   <= cfg_word[BIT_XTAL];
      sink_mode   <= next_sink;
      drive_large <= cfg_word[BIT_DRIVE];
    end
  end
endmodule

/* iopc_pkg.sv */
package iopc_pkg;
  // register byte offsets, one aligned word each
  localparam logic [7:0] ADDR_PA_DATA   = 8'h00;
  localparam logic [7:0] ADDR_PB_DATA   = 8'h04;
  localparam logic [7:0] ADDR_PA_DIR    = 8'h08;
  localparam logic [7:0] ADDR_PB_DIR    = 8'h0c;
  localparam logic [7:0] ADDR_PA_PH     = 8'h10;
  localparam logic [7:0] ADDR_PB_PH     = 8'h14;
  localparam logic [7:0] ADDR_PL        = 8'h18;
  localparam logic [7:0] ADDR_PWR       = 8'h1c;
  localparam logic [7:0] ADDR_PB_OD     = 8'h20;
  localparam logic [7:0] ADDR_PA_WAKE   = 8'h24;
  localparam logic [7:0] ADDR_PB_WAKE   = 8'h28;
  localparam logic [7:0] ADDR_IFLAG     = 8'h2c;
  localparam logic [7:0] ADDR_IEN       = 8'h30;
  localparam logic [7:0] ADDR_PWR1      = 8'h34;
  localparam logic [7:0] ADDR_EDGE      = 8'h38;
  localparam logic [7:0] ADDR_IR        = 8'h3c;
  localparam logic [7:0] ADDR_PERIPH    = 8'h40;
  localparam logic [7:0] ADDR_CFG       = 8'h44;
  // field positions
  localparam int BIT_PA5_PH   = 4;
  localparam int BIT_LVL_FLAG = 1;
  localparam int BIT_GIE      = 7;
  localparam int BIT_EXT_IRQ0_SELECT     = 4;
  localparam int BIT_EXT_IRQ1_SELECT     = 5;
  localparam int BIT_IR_CARRIER_EN     = 0;
  // peripheral-select register fields
  localparam int BIT_T0_SRC   = 0;
  localparam int BIT_T0_LCK   = 1;
  localparam int BIT_T1_SRC   = 2;
  localparam int BIT_T2_SRC   = 3;
  localparam int BIT_T3_SRC   = 4;
  localparam int BIT_CMP_OE   = 5;
  localparam int BIT_PWM1_OE  = 6;
  localparam int BIT_BZ1_EN   = 7;
  localparam int BIT_PWM2_OE  = 8;
  localparam int BIT_BZ2_EN   = 9;
  // configuration word fields
  localparam int BIT_RST_PIN  = 0;
  localparam int BIT_XTAL     = 1;
  localparam int BIT_CLKOUT   = 2;
  localparam int BIT_IR_LARGE = 3;
  localparam int BIT_SINK     = 4;
  localparam int BIT_CSC      = 5;
  localparam int BIT_SMALLSNK = 6;
  localparam int BIT_DRIVE    = 7;
  // reset values
  localparam logic [7:0] RST_ZERO  = 8'h00;
  localparam logic [7:0] RST_DIR   = 8'hff;
  localparam logic [9:0] RST_PERIPH = 10'h000;
  localparam logic [7:0] RST_CFG   = 8'h00;
  // sink strength codes
  typedef enum logic [1:0] {
    IOPC_SINK_SMALL  = 2'b00,
    IOPC_SINK_NORMAL = 2'b01,
    IOPC_SINK_LARGE  = 2'b10,
    IOPC_SINK_CONST  = 2'b11
  } iopc_sink_t;
endpackage

/* iopc_pads.sv */
`timescale 1ns/1ps
// ------------------------------------------
// pad resolution for one port
// ------------------------------------------
module iopc_pads #(parameter int W = 8) (
  // clock for the floating pattern
  input  wire logic         hclk,
  // device side
  input  wire logic [W-1:0] pout,
  input  wire logic [W-1:0] poe_n,
  input  wire logic [W-1:0] pph,
  input  wire logic [W-1:0] ppl,
  // outside drivers
  input  wire logic [W-1:0] ext_en,
  input  wire logic [W-1:0] ext_val,
  // resolved level
  output logic      [W-1:0] pin
);
  logic flt = 1'b0;
  // an undriven pin wanders, so a stale level never looks valid
  always_ff @(posedge hclk) begin
    flt <= ~flt;
  end
  // device drive wins, then the outside driver, then the pulls
  always_comb begin
    for (int i = 0; i < W; i++) begin
      if (!poe_n[i])
        pin[i] = pout[i];
      else if (ext_en[i])
        pin[i] = ext_val[i];
      else if (pph[i] | ppl[i])
        pin[i] = pph[i];
      else
        pin[i] = flt;
    end
  end
endmodule

/* iopc_top_assertions.sv */
`timescale 1ns/1ps
// ------------------------------------------
// port checker
// ------------------------------------------
module iopc_top_chk (
  // clock and reset
  input wire logic       hclk,
  input wire logic       hresetn,
  // observed pins
  input wire logic       hreadyout,
  input wire logic       hresp,
  input wire logic [7:0] pa_in,
  input wire logic [7:0] pa_out,
  input wire logic [7:0] pa_oe_n,
  input wire logic [7:0] pa_pullhigh,
  input wire logic [7:0] pa_pulllow,
  input wire logic [5:0] pb_in,
  input wire logic [5:0] pb_oe_n,
  input wire logic [5:0] pb_pullhigh,
  input wire logic [5:0] pb_pulllow,
  input wire logic       ext_irq0,
  input wire logic       ext_timer_clk_a,
  input wire logic       pin_reset_n,
  input wire logic       level_change_irq
);
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  // zero-wait slave, never an error; ready rises one edge after release
  property p_ready;
    !hresp && (hreadyout || !$past(hresetn));
  endproperty
  a_ready: assert property (p_ready) else $error("bus stall");
  // pulls only on released pins
  property p_pull_a;
    ((pa_pullhigh | pa_pulllow) & ~pa_oe_n) == 8'h00;
  endproperty
  a_pull_a: assert property (p_pull_a) else $error("pull a");
  property p_pull_b;
    ((pb_pullhigh | pb_pulllow) & ~pb_oe_n) == 6'h00;
  endproperty
  a_pull_b: assert property (p_pull_b) else $error("pull b");
  // pins without a pull-low resistor
  property p_no_low;
    (pa_pulllow & 8'hd0) == 8'h00 && pb_pulllow[5:4] == 2'b00;
  endproperty
  a_no_low: assert property (p_no_low) else $error("pulllow");
  // A5 may only sink
  property p_a5_od;
    !pa_oe_n[5] |-> !pa_out[5];
  endproperty
  a_a5_od: assert property (p_a5_od) else $error("a5 drive");
  // two sync stages plus the output flop
  property p_irq0;
    ext_irq0 |-> $past(pb_in[0], 3);
  endproperty
  a_irq0: assert property (p_irq0) else $error("irq0");
  property p_tclk_a;
    ext_timer_clk_a |-> $past(pa_in[4], 3);
  endproperty
  a_tclk_a: assert property (p_tclk_a) else $error("tclk");
  property p_rst_pin;
    !pin_reset_n |-> !$past(pa_in[5], 3);
  endproperty
  a_rst_pin: assert property (p_rst_pin) else $error("rst pin");
  // main scenarios
  c_lvl: cover property (level_change_irq);
  c_irq0: cover property (ext_irq0);
  c_rst: cover property (!pin_reset_n);
endmodule
bind iopc_top iopc_top_chk u_chk (.hclk, .hresetn, .hreadyout, .hresp,
  .pa_in, .pa_out, .pa_oe_n, .pa_pullhigh, .pa_pulllow, .pb_in, .pb_oe_n,
  .pb_pullhigh, .pb_pulllow, .ext_irq0, .ext_timer_clk_a, .pin_reset_n,
  .level_change_irq);

/* test_io_port_pin_control.sv */
`timescale 1ns/1ps
// ------------------------------------------
// port block bench
// ------------------------------------------
module test_io_port_pin_control;
  import iopc_pkg::*;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans, sink_mode;
  logic [2:0]  hsize;
  logic [7:0]  pa_in, pa_out, pa_oe_n, pa_pullhigh, pa_pulllow, pa_val;
  logic [5:0]  pb_in, pb_out, pb_oe_n, pb_pullhigh, pb_pulllow, pb_val;
  logic [7:0]  pa_ext;
  logic        ir_carrier, instr_clk, cmp_out, pwm_one, buzzer_one;
  logic        pwm_two, buzzer_two, level_change_irq, ext_irq0, ext_irq1;
  logic        ext_timer_clk_a, ext_timer_clk_b, pin_reset_n, xtal_mode;
  logic        drive_large;
  int          fail_count = 0;
  int          samples_checked = 0;
  // peripheral select against {clk_a, clk_b, pb3, pb2}
  logic [9:0]  psel [10] = '{10'h003, 10'h001, 10'h004, 10'h008, 10'h010,
                             10'h0e0, 10'h0c0, 10'h080, 10'h300, 10'h200};
  logic [3:0]  pexp [10] = '{4'h0, 4'h8, 4'h8, 4'h4, 4'h4,
                             4'h2, 4'h0, 4'h2, 4'h0, 4'h1};
  // configuration word against {sink_mode, drive_large}
  logic [7:0]  cfgv [4] = '{8'h30, 8'h40, 8'h50, 8'hf0};
  logic [2:0]  sexp [4] = '{{IOPC_SINK_SMALL, 1'b0}, {IOPC_SINK_NORMAL, 1'b0},
                            {IOPC_SINK_LARGE, 1'b0}, {IOPC_SINK_CONST, 1'b1}};
  // 25 MHz clock
  always #20 hclk = ~hclk;
  iopc_top u_dut (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp,
    .pa_in, .pa_out, .pa_oe_n, .pa_pullhigh, .pa_pulllow,
    .pb_in, .pb_out, .pb_oe_n, .pb_pullhigh, .pb_pulllow,
    .ir_carrier, .instr_clk, .cmp_out, .pwm_one, .buzzer_one,
    .pwm_two, .buzzer_two, .level_change_irq, .ext_irq0, .ext_irq1,
    .ext_timer_clk_a, .ext_timer_clk_b, .pin_reset_n, .xtal_mode,
    .sink_mode, .drive_large
  );
  // outside drivers mostly present; port A can let go to show the pulls
  iopc_pads #(.W(8)) u_pad_a (.hclk, .pout(pa_out), .poe_n(pa_oe_n),
    .pph(pa_pullhigh), .ppl(pa_pulllow), .ext_en(pa_ext), .ext_val(pa_val),
    .pin(pa_in));
  iopc_pads #(.W(6)) u_pad_b (.hclk, .pout(pb_out), .poe_n(pb_oe_n),
    .pph(pb_pullhigh), .ppl(pb_pulllow), .ext_en(6'h3f), .ext_val(pb_val),
    .pin(pb_in));
  // ------------------------------------------
  // helpers
  // ------------------------------------------
  task final_report();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task step(input int n);
    repeat (n) @(posedge hclk);
  endtask
  // bounded wait for hready sampled high
  task rdy();
    int n;
    n = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1) begin
      n++;
      if (n > 50) begin
        fail_count++;
        final_report();
      end
      @(posedge hclk);
    end
  endtask
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
            output logic [31:0] q);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= w;
    rdy();
    htrans <= 2'b00;
    hwdata <= d;
    rdy();
    q = hrdata;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    xfer(1'b1, a, d, q);
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    xfer(1'b0, a, 32'h0, q);
    chk(q, e);
  endtask
  task rst();
    hresetn <= 1'b0;
    step(2);
    hresetn <= 1'b1;
    step(1);
  endtask
  // ------------------------------------------
  // main sequence
  // ------------------------------------------
  initial begin
    hclk = 1'b0;
    hresetn = 1'b0;
    hsize = 3'b010;
    {hsel, haddr, htrans, hwrite, hwdata, pa_val, pb_val} = '0;
    pa_ext = 8'hff;
    {ir_carrier, instr_clk, pwm_one, pwm_two} = '0;
    {cmp_out, buzzer_one, buzzer_two} = 3'b111;
    rst();
    rd(ADDR_PA_DIR, 32'hff);
    rd(ADDR_PB_DIR, 32'h3f);
    rd(8'h48, 32'h0);
    pa_val <= 8'h5a;
    step(4);
    rd(ADDR_PA_DATA, 32'h5a);
    // every pull on, all pins still inputs
    wr(ADDR_PA_PH, 32'hff);
    wr(ADDR_PWR, 32'h10);
    wr(ADDR_PL, 32'hff);
    wr(ADDR_PB_PH, 32'h3f);
    step(2);
    chk(32'(pa_pullhigh), 32'hff);
    chk(32'(pa_pulllow), 32'h2f);
    chk(32'(pb_pullhigh), 32'h3f);
    chk(32'(pb_pulllow), 32'h0f);
    // outside driver gone: the pulls alone set the pin levels
    pa_ext <= 8'h00;
    step(4);
    rd(ADDR_PA_DATA, 32'hff);
    pa_ext <= 8'hff;
    wr(ADDR_PA_DIR, 32'h0);
    step(2);
    chk(32'(pa_pullhigh | pa_pulllow), 32'h0);
    wr(ADDR_PA_DATA, 32'ha5);
    step(2);
    chk(32'(pa_oe_n), 32'h20);
    chk(32'(pa_out & 8'hdf), 32'h85);
    wr(ADDR_PB_DIR, 32'h0);
    wr(ADDR_PB_OD, 32'h03);
    wr(ADDR_PB_DATA, 32'h3d);
    step(2);
    chk(32'(pb_oe_n), 32'h01);
    chk(32'(pb_out & 6'h3e), 32'h3c);
    // level change, first masked by the global enable
    rst();
    wr(ADDR_PB_WAKE, 32'h04);
    wr(ADDR_IEN, 32'h02);
    pb_val <= 6'h04;
    // two sync stages: no flag within the first cycle
    rd(ADDR_IFLAG, 32'h0);
    step(8);
    rd(ADDR_IFLAG, 32'h02);
    chk(32'(level_change_irq), 32'h0);
    wr(ADDR_PWR1, 32'h80);
    step(2);
    chk(32'(level_change_irq), 32'h1);
    wr(ADDR_IFLAG, 32'h0);
    step(2);
    chk(32'(level_change_irq), 32'h0);
    // external interrupts take B0 and B1 away from level change
    wr(ADDR_PB_WAKE, 32'h03);
    wr(ADDR_EDGE, 32'h30);
    pb_val <= 6'h07;
    step(8);
    rd(ADDR_IFLAG, 32'h0);
    chk(32'({ext_irq0, ext_irq1}), 32'h3);
    // timer clock pins and B3/B2 output sources
    pa_val <= 8'h12;
    wr(ADDR_PB_DIR, 32'h0);
    for (int i = 0; i < 10; i++) begin
      wr(ADDR_PERIPH, 32'(psel[i]));
      step(2);
      chk(32'({ext_timer_clk_a, ext_timer_clk_b, pb_out[3:2]}),
          32'(pexp[i]));
    end
    // carrier replaces B1 data, then moves to A3
    wr(ADDR_PB_DATA, 32'h02);
    wr(ADDR_IR, 32'h1);
    step(2);
    chk(32'(pb_out[1]), 32'h0);
    ir_carrier <= 1'b1;
    wr(ADDR_CFG, 32'h08);
    step(2);
    chk(32'({pa_out[3], pa_oe_n[3]}), 32'h2);
    wr(ADDR_IR, 32'h0);
    step(2);
    chk(32'(pa_oe_n[3]), 32'h1);
    for (int i = 0; i < 4; i++) begin
      wr(ADDR_CFG, 32'(cfgv[i]));
      step(2);
      chk(32'({sink_mode, drive_large}), 32'(sexp[i]));
    end
    // reset pin, clock out, crystal
    pa_val <= 8'h00;
    wr(ADDR_CFG, 32'h01);
    step(6);
    chk(32'(pin_reset_n), 32'h0);
    instr_clk <= 1'b1;
    wr(ADDR_CFG, 32'h04);
    step(2);
    chk(32'({pa_out[7], pa_oe_n[7], pin_reset_n}), 32'h5);
    wr(ADDR_CFG, 32'h06);
    step(2);
    chk(32'({xtal_mode, pa_out[7]}), 32'h2);
    final_report();
  end
endmodule
